// ===== pft_pkg.sv
package pft_pkg;

	// =========================================================
	// pointer and holding buffer geometry
	localparam int PTR_W = 22;
	localparam int LOW_W = 21;
	localparam int HOLD_N = 32;
	localparam int HOLD_AW = 5;
	localparam int ROW_LSB = 6;
	localparam int HALF_LSB = 5;
	localparam logic [7:0] HOLD_ERASED = 8'hff;

	// =========================================================
	// register selects on the special-function bus
	localparam logic [2:0] SFR_LATCH = 3'h0;
	localparam logic [2:0] SFR_PTR_UPPER = 3'h1;
	localparam logic [2:0] SFR_PTR_HIGH = 3'h2;
	localparam logic [2:0] SFR_PTR_LOW = 3'h3;
	localparam logic [2:0] SFR_CTRL = 3'h4;
	localparam logic [2:0] SFR_UNLOCK = 3'h5;

	// =========================================================
	// control register bit positions
	localparam int CTRL_PM_SEL = 7;
	localparam int CTRL_CFG_SEL = 6;
	localparam int CTRL_ROW_ERASE = 4;
	localparam int CTRL_WR_ERR = 3;
	localparam int CTRL_WR_EN = 2;
	localparam int CTRL_WR_START = 1;

	// =========================================================
	// unlock keys and progress
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
	localparam logic [1:0] UNLOCK_IDLE = 2'h0;
	localparam logic [1:0] UNLOCK_HALF = 2'h1;
	localparam logic [1:0] UNLOCK_ARMED = 2'h2;

	// =========================================================
	// long write timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int LONG_TIME_NS = 2000000;
	localparam int LONG_CYCLES = LONG_TIME_NS / CLK_PERIOD_NS;

	// =========================================================
	// table instruction pointer modes
	typedef enum logic [1:0] {
		PFT_MODE_KEEP = 2'h0,
		PFT_MODE_POST_INC = 2'h1,
		PFT_MODE_POST_DEC = 2'h2,
		PFT_MODE_PRE_INC = 2'h3
	} pft_mode_t;

	// sequencer states
	typedef enum logic [3:0] {
		PFT_IDLE = 4'h1,
		PFT_RD_WAIT = 4'h2,
		PFT_STREAM = 4'h4,
		PFT_TIMED = 4'h8
	} pft_state_t;

endpackage : pft_pkg

// ===== pft_hold_mem.sv
`timescale 1ns/1ps
module pft_hold_mem #(
	parameter int DEPTH = 32,
	parameter int AW = 5,
	parameter int DW = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// whole-buffer return to erased level
	input wire logic clear_all,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port, data one cycle later
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	import pft_pkg::*;

	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] next_mem [DEPTH];
	logic [DW-1:0] next_rdata;

	// =========================================================
	// storage
	// clear beats a same-cycle write; the core is stalled at a long write end, so only a warm reset can meet one
	always_comb begin
		next_mem = mem;
		if (clear_all) begin
			for (int i = 0; i < DEPTH; i++) begin
				next_mem[i] = {DW{1'b1}};
			end
		end else if (we) begin
			next_mem[waddr] = wdata;
		end
		next_rdata = mem[raddr];
	end

	// reset leaves every entry erased
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= {DW{1'b1}};
			end
			rdata <= {DW{1'b1}};
		end else begin
			mem <= next_mem;
			rdata <= next_rdata;
		end
	end

endmodule : pft_hold_mem

// ===== pft_table_access.sv
`timescale 1ns/1ps
// How it works
// (R01) byte latch carries every table transfer
// (R02) pointer is upper, high, low bytes joined
// (R03) top pointer bit picks configuration space
// (R04) auto step touches low 21 bits only
// (R05) four modes: keep, post-inc, post-dec, pre-inc
// (R06) table read fetches byte into latch
// (R07) table write fills holding entry ptr[4:0]
// (R08) programming block comes from upper pointer bits
// (R09) erase clears row ptr[21:6], ignores rest
// (R10) address bit zero picks word half
// (R11) erase unit is one 64-byte row
// (R12) software sets selects, enable, erase before start
// (R13) start accepted only after 55h, AAh unlock
// (R14) start with erase selected begins erase
// (R15) core stalls until timer ends long write
// (R16) long write lasts about two milliseconds
// (R17) programming unit is 32 bytes together
// (R18) flash changes only on long write
// (R19) holding entries erased on reset, after programming
// (R20) erased holding entry leaves flash byte alone
// (R21) aborted or improper write sets error flag
// (R22) hardware clears start bit, core resumes
module pft_table_access #(
	parameter int LONG_CYCLES = pft_pkg::LONG_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic warm_reset,
	// special-function register access
	input wire logic [2:0] sfr_sel,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rd_data,
	// table instructions
	input wire logic tbl_req,
	input wire logic tbl_write,
	input wire pft_pkg::pft_mode_t tbl_mode,
	output logic tbl_done,
	output logic core_stall,
	// flash array
	output logic [20:0] flash_rd_addr,
	input wire logic [15:0] flash_rd_data,
	output logic flash_erase,
	output logic [15:0] flash_erase_row,
	output logic flash_wr,
	output logic [21:0] flash_wr_addr,
	output logic [7:0] flash_wr_data
);
	import pft_pkg::*;

	localparam int TW = $clog2(LONG_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LAST = TW'(LONG_CYCLES - 1);
	localparam logic [5:0] STREAM_END = 6'(HOLD_N);

	// =========================================================
	// state
	pft_state_t state, next_state;
	logic [PTR_W-1:0] ptr, next_ptr;
	logic [7:0] latch, next_latch;
	logic pm_sel, next_pm_sel;
	logic cfg_sel, next_cfg_sel;
	logic row_erase, next_row_erase;
	logic wr_en, next_wr_en;
	logic wr_start, next_wr_start;
	logic wr_err, next_wr_err;
	logic [1:0] unlock, next_unlock;
	logic rd_half, next_rd_half;
	logic [5:0] idx, next_idx;
	logic [TW-1:0] timer, next_timer;
	logic [20:0] next_flash_rd_addr;
	logic next_flash_erase;
	logic [15:0] next_flash_erase_row;
	logic next_flash_wr;
	logic [21:0] next_flash_wr_addr;
	logic [7:0] next_flash_wr_data;
	logic [7:0] next_sfr_rd_data;

	// holding buffer wiring
	logic hold_we, hold_clear;
	logic [HOLD_AW-1:0] hold_waddr, hold_raddr;
	logic [7:0] hold_rdata;

	// pointer arithmetic helpers
	logic [PTR_W-1:0] ptr_inc, ptr_dec, ptr_eff, ptr_after;
	logic ctrl_wr, start_req, start_ok;

	// =========================================================
	// pointer stepping
	always_comb begin
		ptr_inc = {ptr[PTR_W-1], ptr[LOW_W-1:0] + 21'h000001}; // R04
		ptr_dec = {ptr[PTR_W-1], ptr[LOW_W-1:0] - 21'h000001}; // R04
		ptr_eff = (tbl_mode == PFT_MODE_PRE_INC) ? ptr_inc : ptr; // R05
		case (tbl_mode) // R05
			PFT_MODE_KEEP: ptr_after = ptr;
			PFT_MODE_POST_DEC: ptr_after = ptr_dec;
			default: ptr_after = ptr_inc;
		endcase
	end

	// start needs the unlock pair, write enable and the program array
	assign ctrl_wr = sfr_wr && (sfr_sel == SFR_CTRL);
	assign start_req = ctrl_wr && sfr_wdata[CTRL_WR_START] && !wr_start
		&& (state == PFT_IDLE);
	assign start_ok = (unlock == UNLOCK_ARMED) && wr_en && pm_sel && !cfg_sel; // R13 R12

	// handshake outputs
	assign tbl_done = ((state == PFT_IDLE) && tbl_req && tbl_write) || (state == PFT_RD_WAIT);
	assign core_stall = (state == PFT_STREAM) || (state == PFT_TIMED); // R15

	// holding buffer ports
	assign hold_we = (state == PFT_IDLE) && tbl_req && tbl_write; // R18
	assign hold_waddr = ptr_eff[HOLD_AW-1:0]; // R07
	assign hold_raddr = idx[HOLD_AW-1:0];
	assign hold_clear = warm_reset
		|| ((state == PFT_TIMED) && (timer == TIMER_LAST) && !row_erase); // R19

	pft_hold_mem #(
		.DEPTH(HOLD_N),
		.AW(HOLD_AW),
		.DW(8)
	) u_hold (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear_all(hold_clear),
		.we(hold_we),
		.waddr(hold_waddr),
		.wdata(latch), // R07
		.raddr(hold_raddr),
		.rdata(hold_rdata)
	);

	// =========================================================
	// sequencer and register file next values
	always_comb begin
		next_state = state;
		next_ptr = ptr;
		next_latch = latch;
		next_pm_sel = pm_sel;
		next_cfg_sel = cfg_sel;
		next_row_erase = row_erase;
		next_wr_en = wr_en;
		next_wr_start = wr_start;
		next_wr_err = wr_err;
		next_unlock = unlock;
		next_rd_half = rd_half;
		next_idx = idx;
		next_timer = timer;
		next_flash_rd_addr = flash_rd_addr;
		next_flash_erase = 1'b0;
		next_flash_erase_row = flash_erase_row;
		next_flash_wr = 1'b0;
		next_flash_wr_addr = flash_wr_addr;
		next_flash_wr_data = flash_wr_data;

		// register writes from the core; pointer bytes join into one
		if (sfr_wr) begin
			case (sfr_sel)
				SFR_LATCH: next_latch = sfr_wdata; // R01
				SFR_PTR_UPPER: next_ptr[PTR_W-1:16] = sfr_wdata[5:0]; // R02
				SFR_PTR_HIGH: next_ptr[15:8] = sfr_wdata; // R02
				SFR_PTR_LOW: next_ptr[7:0] = sfr_wdata; // R02
				SFR_CTRL: begin
					next_pm_sel = sfr_wdata[CTRL_PM_SEL];
					next_cfg_sel = sfr_wdata[CTRL_CFG_SEL];
					next_row_erase = sfr_wdata[CTRL_ROW_ERASE];
					next_wr_en = sfr_wdata[CTRL_WR_EN];
					next_wr_err = sfr_wdata[CTRL_WR_ERR];
				end
				default: ;
			endcase
			// any register write other than the keys breaks the unlock
			if (sfr_sel == SFR_UNLOCK) begin
				if (sfr_wdata == UNLOCK_KEY1) begin
					next_unlock = UNLOCK_HALF; // R13
				end else if (sfr_wdata == UNLOCK_KEY2 && unlock == UNLOCK_HALF) begin
					next_unlock = UNLOCK_ARMED; // R13
				end else begin
					next_unlock = UNLOCK_IDLE;
				end
			end else begin
				next_unlock = UNLOCK_IDLE;
			end
		end

		// start request: accepted or flagged as improper
		if (start_req) begin
			if (start_ok) begin
				next_wr_start = 1'b1;
				next_timer = '0;
				next_idx = '0;
				if (sfr_wdata[CTRL_ROW_ERASE]) begin
					next_state = PFT_TIMED; // R14
					next_flash_erase = 1'b1; // R11
					next_flash_erase_row = ptr[PTR_W-1:ROW_LSB]; // R09
				end else begin
					next_state = PFT_STREAM; // R17
				end
			end else begin
				next_wr_err = 1'b1; // R21
			end
		end

		case (state)
			PFT_IDLE: begin
				if (tbl_req) begin
					next_ptr = ptr_after; // R05
					if (!tbl_write) begin
						// msb of the word address is the configuration space select
						next_flash_rd_addr = ptr_eff[PTR_W-1:1]; // R06 R03
						next_rd_half = ptr_eff[0]; // R10
						next_state = PFT_RD_WAIT;
					end
				end
			end
			PFT_RD_WAIT: begin
				next_latch = rd_half ? flash_rd_data[15:8] : flash_rd_data[7:0]; // R10 R06
				next_state = PFT_IDLE;
			end
			PFT_STREAM: begin
				// entry idx-1 is on the read port; erased entries are skipped
				if (idx != 6'h00 && hold_rdata != HOLD_ERASED) begin
					next_flash_wr = 1'b1; // R20
					next_flash_wr_addr = {ptr[PTR_W-1:HALF_LSB], 5'(idx - 6'h01)}; // R08
					next_flash_wr_data = hold_rdata;
				end
				next_idx = idx + 6'h01;
				if (idx == STREAM_END) begin
					next_state = PFT_TIMED;
				end
			end
			PFT_TIMED: begin
				next_timer = timer + TW'(1); // R16
				if (timer == TIMER_LAST) begin
					next_wr_start = 1'b0; // R22
					next_wr_err = 1'b0; // R21
					next_state = PFT_IDLE; // R15
				end
			end
			default: next_state = PFT_IDLE;
		endcase

		// warm reset aborts a long write and leaves the error behind
		if (warm_reset) begin
			next_state = PFT_IDLE;
			next_wr_start = 1'b0;
			next_unlock = UNLOCK_IDLE;
			next_wr_err = next_wr_err || core_stall; // R21
		end
	end

	// =========================================================
	// register read mux, one cycle of latency
	always_comb begin
		case (sfr_sel)
			SFR_LATCH: next_sfr_rd_data = latch;
			SFR_PTR_UPPER: next_sfr_rd_data = {2'h0, ptr[PTR_W-1:16]};
			SFR_PTR_HIGH: next_sfr_rd_data = ptr[15:8];
			SFR_PTR_LOW: next_sfr_rd_data = ptr[7:0];
			SFR_CTRL: next_sfr_rd_data = {pm_sel, cfg_sel, 1'b0, row_erase, wr_err,
				wr_en, wr_start, 1'b0};
			default: next_sfr_rd_data = 8'h00;
		endcase
	end

	// =========================================================
	// registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PFT_IDLE;
			ptr <= '0;
			latch <= 8'h00;
			pm_sel <= 1'b0;
			cfg_sel <= 1'b0;
			row_erase <= 1'b0;
			wr_en <= 1'b0;
			wr_start <= 1'b0;
			wr_err <= 1'b0;
			unlock <= UNLOCK_IDLE;
			rd_half <= 1'b0;
			idx <= 6'h00;
			timer <= '0;
			flash_rd_addr <= 21'h000000;
			flash_erase <= 1'b0;
			flash_erase_row <= 16'h0000;
			flash_wr <= 1'b0;
			flash_wr_addr <= 22'h000000;
			flash_wr_data <= 8'h00;
			sfr_rd_data <= 8'h00;
		end else begin
			state <= next_state;
			ptr <= next_ptr;
			latch <= next_latch;
			pm_sel <= next_pm_sel;
			cfg_sel <= next_cfg_sel;
			row_erase <= next_row_erase;
			wr_en <= next_wr_en;
			wr_start <= next_wr_start;
			wr_err <= next_wr_err;
			unlock <= next_unlock;
			rd_half <= next_rd_half;
			idx <= next_idx;
			timer <= next_timer;
			flash_rd_addr <= next_flash_rd_addr;
			flash_erase <= next_flash_erase;
			flash_erase_row <= next_flash_erase_row;
			flash_wr <= next_flash_wr;
			flash_wr_addr <= next_flash_wr_addr;
			flash_wr_data <= next_flash_wr_data;
			sfr_rd_data <= next_sfr_rd_data;
		end
	end

	// =========================================================
	// checks
	sequence s_read_req;
		(state == PFT_IDLE) && tbl_req && !tbl_write && !warm_reset;
	endsequence

	sequence s_good_start;
		start_req && start_ok && !warm_reset;
	endsequence

	a_read_done_next: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		s_read_req |=> tbl_done ##1 state == PFT_IDLE)
		else $error("table read did not finish in one wait cycle");

	a_read_half_sel: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		(state == PFT_RD_WAIT) && !(sfr_wr && sfr_sel == SFR_LATCH) |=>
		latch == ($past(rd_half) ? $past(flash_rd_data[15:8]) : $past(flash_rd_data[7:0])))
		else $error("latch took the wrong half of the word");

	a_ptr_top_kept: assert property (@(posedge mclk) disable iff (!rst_n) // R04
		(state == PFT_IDLE) && tbl_req && !sfr_wr |=> ptr[PTR_W-1] == $past(ptr[PTR_W-1]))
		else $error("table step changed the top pointer bit");

	a_no_start_locked: assert property (@(posedge mclk) disable iff (!rst_n) // R13
		start_req && (unlock != UNLOCK_ARMED) && !warm_reset |=> !wr_start && wr_err)
		else $error("start accepted without unlock");

	a_erase_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		s_good_start ##0 sfr_wdata[CTRL_ROW_ERASE] |=>
		flash_erase && flash_erase_row == $past(ptr[PTR_W-1:ROW_LSB]) ##1 !flash_erase)
		else $error("erase did not start on accepted start");

	a_stall_held: assert property (@(posedge mclk) disable iff (!rst_n || warm_reset) // R15
		s_good_start |=> core_stall [*8])
		else $error("core not stalled during long write");

	a_end_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R22
		(state == PFT_TIMED) && (timer == TIMER_LAST) && !warm_reset |=>
		!wr_start && !core_stall && !wr_err && state == PFT_IDLE)
		else $error("long write end did not release");

	a_no_erased_write: assert property (@(posedge mclk) disable iff (!rst_n) // R20
		flash_wr |-> flash_wr_data != HOLD_ERASED && $past(state == PFT_STREAM))
		else $error("erased holding byte written or write outside stream");

	a_abort_flags: assert property (@(posedge mclk) disable iff (!rst_n) // R21
		warm_reset && core_stall |=> wr_err && !wr_start && state == PFT_IDLE)
		else $error("aborted long write left no error");

endmodule : pft_table_access

// ===== pft_flash_model.sv
`timescale 1ns/1ps
// =========================================================
// flash array stand-in: word reads, row erase, one-way byte programming
module pft_flash_model (
	// clock
	input wire logic mclk,
	// array port
	input wire logic [20:0] flash_rd_addr,
	output logic [15:0] flash_rd_data,
	input wire logic flash_erase,
	input wire logic [15:0] flash_erase_row,
	input wire logic flash_wr,
	input wire logic [21:0] flash_wr_addr,
	input wire logic [7:0] flash_wr_data
);
	logic [15:0] mem [int];
	logic [15:0] mask;

	// untouched words hold a pattern tied to their address
	function automatic logic [15:0] word_at(input logic [20:0] wa);
		return mem.exists(wa) ? mem[wa] : ({wa[20:13], wa[7:0]} ^ 16'h5a3c);
	endfunction : word_at

	// the sequencer samples the word one edge after it registers the address,
	// so the answer has to stand from mid-cycle, not arrive a full cycle late
	always @(negedge mclk) begin
		flash_rd_data <= word_at(flash_rd_addr);
	end

	// erase and program land on the rising edge that carries the pulse
	always @(posedge mclk) begin
		if (flash_erase) begin
			for (int i = 0; i < 32; i++) begin
				mem[{flash_erase_row, 5'h0} + i] = 16'hffff;
			end
		end
		if (flash_wr) begin
			mask = flash_wr_addr[0] ? {flash_wr_data, 8'hff} : {8'hff, flash_wr_data};
			mem[flash_wr_addr[21:1]] = word_at(flash_wr_addr[21:1]) & mask;
		end
	end
endmodule : pft_flash_model

// ===== program_flash_table_access_tb.sv
`timescale 1ns/1ps
module program_flash_table_access_tb;
	import pft_pkg::*;
	localparam int LC = 20;
	logic mclk, rst_n, warm_reset, sfr_wr, tbl_req, tbl_write, tbl_done, core_stall;
	logic flash_erase, flash_wr;
	logic [2:0] sfr_sel;
	logic [7:0] sfr_wdata, sfr_rd_data, flash_wr_data;
	logic [20:0] flash_rd_addr;
	logic [15:0] flash_rd_data, flash_erase_row, row_seen;
	logic [21:0] flash_wr_addr, last_wa;
	pft_mode_t tbl_mode;
	int fails, check_count, n_wr, n_er, n_st;

	pft_table_access #(.LONG_CYCLES(LC)) i_pft_table_access (.mclk(mclk), .rst_n(rst_n),
		.warm_reset(warm_reset), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rd_data(sfr_rd_data), .tbl_req(tbl_req), .tbl_write(tbl_write),
		.tbl_mode(tbl_mode), .tbl_done(tbl_done), .core_stall(core_stall),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
		.flash_erase(flash_erase), .flash_erase_row(flash_erase_row), .flash_wr(flash_wr),
		.flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data));

	pft_flash_model i_pft_flash_model (.mclk(mclk), .flash_rd_addr(flash_rd_addr),
		.flash_rd_data(flash_rd_data), .flash_erase(flash_erase),
		.flash_erase_row(flash_erase_row), .flash_wr(flash_wr),
		.flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data));

	// =========================================================
	// clock and array traffic tally
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// counts are reset per operation, so they only see one long write
	always @(posedge mclk) begin
		n_st += core_stall;
		n_er += flash_erase;
		n_wr += flash_wr;
		if (flash_wr) last_wa = flash_wr_addr;
		if (flash_erase) row_seen = flash_erase_row;
	end

	// =========================================================
	// helpers
	function automatic logic [7:0] dflt(input logic [21:0] p);
		logic [15:0] w;
		w = {p[21:14], p[8:1]} ^ 16'h5a3c;
		return p[0] ? w[15:8] : w[7:0];
	endfunction : dflt

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(negedge mclk);
		sfr_sel = sel;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask : wr

	// read data is registered, so it is taken one cycle after the select
	task automatic rc(input string n, input logic [2:0] sel, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		@(negedge mclk);
		sfr_sel = sel;
		@(negedge mclk);
		check(n, sfr_rd_data & m, e);
	endtask : rc

	task automatic setp(input logic [21:0] p);
		wr(SFR_PTR_UPPER, {2'h0, p[21:16]});
		wr(SFR_PTR_HIGH, p[15:8]);
		wr(SFR_PTR_LOW, p[7:0]);
	endtask : setp

	task automatic chkp(input logic [21:0] e);
		rc("ptr upper", SFR_PTR_UPPER, {2'h0, e[21:16]});
		rc("ptr high", SFR_PTR_HIGH, e[15:8]);
		rc("ptr low", SFR_PTR_LOW, e[7:0]);
	endtask : chkp

	// a read holds the port for two cycles, the latch is settled after that
	task automatic tbl(input logic w, input pft_mode_t m);
		@(negedge mclk);
		tbl_req = 1'b1;
		tbl_write = w;
		tbl_mode = m;
		#1 check("done at request", tbl_done, w);
		@(negedge mclk);
		tbl_req = 1'b0;
		#1 check("done after request", tbl_done, !w);
		@(negedge mclk);
	endtask : tbl

	task automatic trd(input logic [21:0] p, input logic [7:0] e);
		setp(p);
		tbl(1'b0, PFT_MODE_KEEP);
		rc("flash byte", SFR_LATCH, e);
	endtask : trd

	task automatic go(input logic [7:0] c, input logic abort);
		// selects and enable go in first; the start write right after the keys
		wr(SFR_CTRL, c & 8'hfd);
		wr(SFR_UNLOCK, UNLOCK_KEY1);
		wr(SFR_UNLOCK, UNLOCK_KEY2);
		n_wr = 0;
		n_er = 0;
		n_st = 0;
		wr(SFR_CTRL, c);
		repeat (3) @(negedge mclk);
		if (abort) begin
			warm_reset = 1'b1;
			@(negedge mclk);
			warm_reset = 1'b0;
		end
		for (int i = 0; i < 200 && core_stall; i++) begin
			@(negedge mclk);
		end
		check("stall end", core_stall, 1'b0);
	endtask : go

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// =========================================================
	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		$display("watchdog expired");
		wrap_up();
	end

	// =========================================================
	// test sequence
	initial begin
		{rst_n, warm_reset, sfr_wr, tbl_req, tbl_write, sfr_sel, sfr_wdata} = '0;
		tbl_mode = PFT_MODE_KEEP;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		chkp(22'h000000);
		rc("ctrl", SFR_CTRL, 8'h00);
		wr(SFR_PTR_UPPER, 8'hff);
		rc("ptr upper", SFR_PTR_UPPER, 8'h3f);
		wr(SFR_PTR_HIGH, 8'hff);
		wr(SFR_PTR_LOW, 8'hff);
		$display("test registers done");
		// wrap of the low 21 bits keeps the space select bit
		tbl(1'b0, PFT_MODE_POST_INC);
		chkp(22'h200000);
		rc("latch", SFR_LATCH, dflt(22'h3fffff));
		tbl(1'b0, PFT_MODE_POST_DEC);
		chkp(22'h3fffff);
		trd(22'h000122, dflt(22'h000122));
		tbl(1'b0, PFT_MODE_PRE_INC);
		rc("latch", SFR_LATCH, dflt(22'h000123));
		chkp(22'h000123);
		$display("test pointer modes done");
		// two bytes of the upper half of row 5, the rest left erased
		setp(22'h000160);
		wr(SFR_LATCH, 8'h12);
		tbl(1'b1, PFT_MODE_POST_INC);
		wr(SFR_LATCH, 8'h34);
		tbl(1'b1, PFT_MODE_POST_INC);
		trd(22'h000160, dflt(22'h000160));
		go(8'h86, 1'b0);
		check("prog bytes", n_wr, 2);
		check("prog addr", last_wa, 22'h000161);
		check("prog stall", n_st, 33 + LC);
		rc("ctrl", SFR_CTRL, 8'h00, 8'h0a);
		trd(22'h000160, dflt(22'h000160) & 8'h12);
		trd(22'h000161, dflt(22'h000161) & 8'h34);
		go(8'h86, 1'b0);
		check("refill", n_wr, 0);
		$display("test programming done");
		setp(22'h000175);
		go(8'h96, 1'b0);
		check("erase pulses", n_er, 1);
		check("erase row", row_seen, 16'h0005);
		check("erase stall", n_st, LC);
		trd(22'h000140, 8'hff);
		trd(22'h00017f, 8'hff);
		trd(22'h000180, dflt(22'h000180));
		$display("test erase done");
		// start without unlock, then an unlock broken by another write
		n_st = 0;
		wr(SFR_CTRL, 8'h86);
		rc("ctrl", SFR_CTRL, 8'h08, 8'h0a);
		wr(SFR_CTRL, 8'h84);
		rc("ctrl", SFR_CTRL, 8'h00, 8'h08);
		wr(SFR_UNLOCK, UNLOCK_KEY1);
		wr(SFR_UNLOCK, UNLOCK_KEY2);
		wr(SFR_LATCH, 8'h00);
		wr(SFR_CTRL, 8'h86);
		rc("ctrl", SFR_CTRL, 8'h08, 8'h0a);
		check("no stall", n_st, 0);
		go(8'h96, 1'b1);
		rc("ctrl", SFR_CTRL, 8'h08, 8'h0a);
		$display("test refusals done");
		wrap_up();
	end
endmodule : program_flash_table_access_tb
